// *** hw/tsfs_pkg.sv ***
// Purpose: shared constants and types for the temperature sense and feature set command block
// Assumes: ata style 8-bit command block registers
// Notes: every code and field position except the link feature bits, set in the decoder, lives here; reset values other than the transfer mode sit in the engine
package tsfs_pkg;
  // ----------------------------------------------------------------
  // command opcodes and feature codes
  // ----------------------------------------------------------------
  localparam logic [7:0] TSFS_OP_TEMP_SENSE = 8'hF0;
  localparam logic [7:0] TSFS_OP_SET_FEATURE = 8'hEF;
  localparam logic [7:0] TSFS_TEMP_SUBCODE = 8'h01;
  localparam logic [7:0] TSFS_FC_WC_EN = 8'h02;
  localparam logic [7:0] TSFS_FC_XFER_MODE = 8'h03;
  localparam logic [7:0] TSFS_FC_APM_EN = 8'h05;
  localparam logic [7:0] TSFS_FC_PUIS_EN = 8'h06;
  localparam logic [7:0] TSFS_FC_PUIS_SPINUP = 8'h07;
  localparam logic [7:0] TSFS_FC_LINK_EN = 8'h10;
  localparam logic [7:0] TSFS_FC_SECTOR_TIME = 8'h43;
  localparam logic [7:0] TSFS_FC_EPC = 8'h4A;
  localparam logic [7:0] TSFS_FC_RLA_DIS = 8'h55;
  localparam logic [7:0] TSFS_FC_REVERT_DIS = 8'h66;
  localparam logic [7:0] TSFS_FC_WC_DIS = 8'h82;
  localparam logic [7:0] TSFS_FC_APM_DIS = 8'h85;
  localparam logic [7:0] TSFS_FC_PUIS_DIS = 8'h86;
  localparam logic [7:0] TSFS_FC_LINK_DIS = 8'h90;
  localparam logic [7:0] TSFS_FC_RLA_EN = 8'hAA;
  localparam logic [7:0] TSFS_FC_REVERT_EN = 8'hCC;
  // ----------------------------------------------------------------
  // link feature selectors, power levels, transfer mode fields
  // ----------------------------------------------------------------
  localparam logic [7:0] TSFS_LINK_OFFSET = 8'h01;
  localparam logic [7:0] TSFS_LINK_AUTOACT = 8'h02;
  localparam logic [7:0] TSFS_LINK_DIPM = 8'h03;
  localparam logic [7:0] TSFS_LINK_INORDER = 8'h04;
  localparam logic [7:0] TSFS_LINK_PRESERVE = 8'h06;
  localparam int TSFS_LINK_BITS = 5;
  localparam logic [7:0] TSFS_APM_ABORT_LO = 8'h00;
  localparam logic [7:0] TSFS_APM_ABORT_HI = 8'hFF;
  localparam logic [7:0] TSFS_APM_IDLE_MIN = 8'hC0;
  localparam logic [7:0] TSFS_APM_LPI_MIN = 8'h80;
  localparam logic [1:0] TSFS_DEEP_IDLE = 2'h0;
  localparam logic [1:0] TSFS_DEEP_LPI = 2'h1;
  localparam logic [1:0] TSFS_DEEP_LRPM = 2'h2;
  localparam int TSFS_XFER_TYPE_LSB = 3;
  localparam logic [4:0] TSFS_XT_PIO_DEF = 5'h00;
  localparam logic [4:0] TSFS_XT_PIO_FC = 5'h01;
  localparam logic [4:0] TSFS_XT_MWDMA = 5'h04;
  localparam logic [4:0] TSFS_XT_UDMA = 5'h08;
  localparam logic [2:0] TSFS_PIO_DEF_MAX = 3'h1;
  localparam logic [2:0] TSFS_PIO_FC_MAX = 3'h4;
  localparam logic [2:0] TSFS_MWDMA_MAX = 3'h2;
  localparam logic [2:0] TSFS_UDMA_MAX = 3'h6;
  localparam logic [7:0] TSFS_XFER_RESET = 8'h00;
  // ----------------------------------------------------------------
  // error and status bit positions, temperature codes
  // ----------------------------------------------------------------
  localparam int TSFS_ERR_ABT = 2;
  localparam int TSFS_ST_BSY = 7;
  localparam int TSFS_ST_RDY = 6;
  localparam int TSFS_ST_ERR = 0;
  localparam logic [7:0] TSFS_TEMP_LOW = 8'h00;
  localparam logic [7:0] TSFS_TEMP_HIGH = 8'hFF;
  localparam logic [9:0] TSFS_TEMP_OFS = 10'h028;
  localparam logic [9:0] TSFS_TEMP_MAX_HALF = 10'h0FE;
  localparam int TSFS_ID85_WC_BIT = 5;
  localparam int TSFS_ID129_WC_BIT = 0;
  typedef enum logic [1:0] {
    TSFS_ST_IDLE = 2'b00,
    TSFS_ST_EXEC = 2'b01,
    TSFS_ST_DONE = 2'b10
  } tsfs_state_t;
endpackage

// *** hw/tsfs_cmd_if.sv ***
// Purpose: carries a decoded command between the command front end and the feature decoder
// Assumes: single clock domain
// Notes: decoder answers combinationally
`timescale 1ns/1ps
interface tsfs_cmd_if;
  logic [7:0] feature;
  logic [7:0] count;
  logic wc_allowed;
  logic abort;
  logic wc_set;
  logic wc_val;
  logic rla_set;
  logic rla_val;
  logic revert_set;
  logic revert_val;
  logic apm_set;
  logic apm_val;
  logic [1:0] apm_deep;
  logic puis_set;
  logic puis_val;
  logic spinup;
  logic link_set;
  logic link_val;
  logic [4:0] link_mask;
  logic xfer_set;
  logic sector_time;
  logic extended_power_condition_group;
  modport ctrl (output feature, count, wc_allowed,
    input abort, wc_set, wc_val, rla_set, rla_val, revert_set, revert_val, apm_set, apm_val,
    apm_deep, puis_set, puis_val, spinup, link_set, link_val, link_mask, xfer_set, sector_time, extended_power_condition_group);
  modport dec (input feature, count, wc_allowed,
    output abort, wc_set, wc_val, rla_set, rla_val, revert_set, revert_val, apm_set, apm_val,
    apm_deep, puis_set, puis_val, spinup, link_set, link_val, link_mask, xfer_set, sector_time, extended_power_condition_group);
endinterface

// *** hw/tsfs_feature_dec.sv ***
// Purpose: decodes one feature-setting request into update strobes and abort
// Assumes: inputs stable during the execute cycle
// Notes: pure combinational, no state
`timescale 1ns/1ps
module tsfs_feature_dec (
  tsfs_cmd_if.dec cmd
);
  import tsfs_pkg::*;
  logic [4:0] xtype;
  logic [2:0] xmode;
  logic xfer_ok;

  // ----------------------------------------------------------------
  // transfer mode selector check
  // ----------------------------------------------------------------
  always_comb begin
    xtype = cmd.count[7:TSFS_XFER_TYPE_LSB];
    xmode = cmd.count[TSFS_XFER_TYPE_LSB-1:0];
    case (xtype)
      TSFS_XT_PIO_DEF: xfer_ok = (xmode <= TSFS_PIO_DEF_MAX);
      TSFS_XT_PIO_FC: xfer_ok = (xmode <= TSFS_PIO_FC_MAX);
      TSFS_XT_MWDMA: xfer_ok = (xmode <= TSFS_MWDMA_MAX);
      TSFS_XT_UDMA: xfer_ok = (xmode <= TSFS_UDMA_MAX);
      default: xfer_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // feature code decode; unknown codes abort
  // ----------------------------------------------------------------
  always_comb begin
    cmd.abort = 1'b0;
    cmd.wc_set = 1'b0;
    cmd.wc_val = 1'b0;
    cmd.rla_set = 1'b0;
    cmd.rla_val = 1'b0;
    cmd.revert_set = 1'b0;
    cmd.revert_val = 1'b0;
    cmd.apm_set = 1'b0;
    cmd.apm_val = 1'b0;
    cmd.apm_deep = TSFS_DEEP_IDLE;
    cmd.puis_set = 1'b0;
    cmd.puis_val = 1'b0;
    cmd.spinup = 1'b0;
    cmd.link_set = 1'b0;
    cmd.link_val = 1'b0;
    cmd.link_mask = '0;
    cmd.xfer_set = 1'b0;
    cmd.sector_time = 1'b0;
    cmd.extended_power_condition_group = 1'b0;
    case (cmd.feature)
      TSFS_FC_WC_EN: begin
        // accepted without error, but stays off once spares are exhausted
        cmd.wc_set = 1'b1;
        cmd.wc_val = cmd.wc_allowed;
      end
      TSFS_FC_WC_DIS: cmd.wc_set = 1'b1;
      TSFS_FC_RLA_EN: begin
        cmd.rla_set = 1'b1;
        cmd.rla_val = 1'b1;
      end
      TSFS_FC_RLA_DIS: cmd.rla_set = 1'b1;
      TSFS_FC_REVERT_EN: begin
        cmd.revert_set = 1'b1;
        cmd.revert_val = 1'b1;
      end
      TSFS_FC_REVERT_DIS: cmd.revert_set = 1'b1;
      TSFS_FC_APM_EN: begin
        if (cmd.count == TSFS_APM_ABORT_LO || cmd.count == TSFS_APM_ABORT_HI) begin
          cmd.abort = 1'b1;
        end else begin
          cmd.apm_set = 1'b1;
          cmd.apm_val = 1'b1;
          if (cmd.count >= TSFS_APM_IDLE_MIN) begin
            cmd.apm_deep = TSFS_DEEP_IDLE;
          end else if (cmd.count >= TSFS_APM_LPI_MIN) begin
            cmd.apm_deep = TSFS_DEEP_LPI;
          end else begin
            cmd.apm_deep = TSFS_DEEP_LRPM;
          end
        end
      end
      TSFS_FC_APM_DIS: cmd.apm_set = 1'b1;
      TSFS_FC_PUIS_EN: begin
        cmd.puis_set = 1'b1;
        cmd.puis_val = 1'b1;
      end
      TSFS_FC_PUIS_DIS: cmd.puis_set = 1'b1;
      TSFS_FC_PUIS_SPINUP: cmd.spinup = 1'b1;
      TSFS_FC_LINK_EN, TSFS_FC_LINK_DIS: begin
        cmd.link_val = (cmd.feature == TSFS_FC_LINK_EN);
        cmd.link_set = 1'b1;
        case (cmd.count)
          TSFS_LINK_OFFSET: cmd.link_mask = 5'b00001;
          TSFS_LINK_AUTOACT: cmd.link_mask = 5'b00010;
          TSFS_LINK_DIPM: cmd.link_mask = 5'b00100;
          TSFS_LINK_INORDER: cmd.link_mask = 5'b01000;
          TSFS_LINK_PRESERVE: cmd.link_mask = 5'b10000;
          default: begin
            cmd.link_set = 1'b0;
            cmd.abort = 1'b1;
          end
        endcase
      end
      TSFS_FC_XFER_MODE: begin
        cmd.xfer_set = xfer_ok;
        cmd.abort = ~xfer_ok;
      end
      TSFS_FC_SECTOR_TIME: cmd.sector_time = 1'b1;
      TSFS_FC_EPC: cmd.extended_power_condition_group = 1'b1;
      default: cmd.abort = 1'b1;
    endcase
  end
endmodule // tsfs_feature_dec

// *** hw/tsfs_cmd_engine.sv ***
// Purpose: executes the temperature sense and feature set commands from the command block
// Assumes: host writes feature and count, then pulses the command strobe with the opcode
// Notes: one execute cycle per command; other opcodes are left for other blocks
`timescale 1ns/1ps
module tsfs_cmd_engine (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_strobe_in,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic [7:0] feature_in,
  input wire logic [7:0] sector_count_in,
  input wire logic [9:0] temp_half_deg_in,
  input wire logic spares_exhausted_in,
  output logic [7:0] command_error_flags_out,
  output logic [7:0] device_status_flags_out,
  output logic [7:0] sector_count_out,
  output logic done_out,
  output logic write_cache_out,
  output logic read_ahead_out,
  output logic revert_defaults_out,
  output logic release_irq_out,
  output logic apm_enable_out,
  output logic [1:0] apm_deep_out,
  output logic [7:0] apm_level_out,
  output logic puis_enable_out,
  output logic spinup_req_out,
  output logic [tsfs_pkg::TSFS_LINK_BITS-1:0] link_features_out,
  output logic [7:0] xfer_mode_out,
  output logic sector_time_req_out,
  output logic extended_power_condition_group_out,
  output logic [15:0] identify_word85_out,
  output logic [15:0] identify_word129_out
);
  import tsfs_pkg::*;

  // temperature code from half-degree steps above minus twenty
  function automatic logic [7:0] tsfs_temp_code(input logic [9:0] half);
    if (half == '0) begin
      return TSFS_TEMP_LOW;
    end else if (half > TSFS_TEMP_MAX_HALF) begin
      return TSFS_TEMP_HIGH;
    end else begin
      return half[7:0];
    end
  endfunction

  tsfs_cmd_if cmd ();
  tsfs_state_t state_r, state_nxt;
  logic [7:0] opcode_r, opcode_nxt;
  logic [7:0] feature_r, feature_nxt;
  logic [7:0] count_r, count_nxt;
  logic [7:0] err_r, err_nxt;
  logic [7:0] stat_r, stat_nxt;
  logic [7:0] scnt_r, scnt_nxt;
  logic done_r, done_nxt;
  logic wc_r, wc_nxt;
  logic rla_r, rla_nxt;
  logic revert_r, revert_nxt;
  logic apm_r, apm_nxt;
  logic [1:0] deep_r, deep_nxt;
  logic [7:0] level_r, level_nxt;
  logic puis_r, puis_nxt;
  logic spin_r, spin_nxt;
  logic [TSFS_LINK_BITS-1:0] link_r, link_nxt;
  logic [7:0] xfer_r, xfer_nxt;
  logic stime_r, stime_nxt;
  logic epc_r, epc_nxt;
  logic spare_r, spare_nxt;
  logic abort_now;

  tsfs_feature_dec u_dec (
    .cmd(cmd)
  );

  // ----------------------------------------------------------------
  // decoder hookup
  // ----------------------------------------------------------------
  assign cmd.feature = feature_r;
  assign cmd.count = count_r;
  assign cmd.wc_allowed = ~spare_r;

  // ----------------------------------------------------------------
  // command sequence and feature state, next values
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    opcode_nxt = opcode_r;
    feature_nxt = feature_r;
    count_nxt = count_r;
    err_nxt = err_r;
    stat_nxt = stat_r;
    scnt_nxt = scnt_r;
    done_nxt = 1'b0;
    wc_nxt = wc_r;
    rla_nxt = rla_r;
    revert_nxt = revert_r;
    apm_nxt = apm_r;
    deep_nxt = deep_r;
    level_nxt = level_r;
    puis_nxt = puis_r;
    spin_nxt = 1'b0;
    link_nxt = link_r;
    xfer_nxt = xfer_r;
    stime_nxt = 1'b0;
    epc_nxt = 1'b0;
    spare_nxt = spare_r | spares_exhausted_in; // latches until reset
    abort_now = 1'b0;
    case (state_r)
      TSFS_ST_IDLE: begin
        // only our two opcodes are claimed; others fall through silently
        if (cmd_strobe_in && (cmd_opcode_in == TSFS_OP_TEMP_SENSE || cmd_opcode_in == TSFS_OP_SET_FEATURE)) begin
          opcode_nxt = cmd_opcode_in;
          feature_nxt = feature_in;
          count_nxt = sector_count_in;
          stat_nxt = '0;
          stat_nxt[TSFS_ST_BSY] = 1'b1;
          state_nxt = TSFS_ST_EXEC;
        end
      end
      TSFS_ST_EXEC: begin
        if (opcode_r == TSFS_OP_TEMP_SENSE) begin
          // no spin-up gate: standby state is never consulted here
          if (feature_r != TSFS_TEMP_SUBCODE) begin
            abort_now = 1'b1;
          end else begin
            scnt_nxt = tsfs_temp_code(temp_half_deg_in);
          end
        end else begin
          abort_now = cmd.abort;
          if (cmd.wc_set) begin
            wc_nxt = cmd.wc_val;
          end
          if (cmd.rla_set) begin
            rla_nxt = cmd.rla_val;
          end
          if (cmd.revert_set) begin
            revert_nxt = cmd.revert_val;
          end
          if (cmd.apm_set) begin
            apm_nxt = cmd.apm_val;
            deep_nxt = cmd.apm_deep;
            level_nxt = cmd.apm_val ? count_r : '0;
          end
          if (cmd.puis_set) begin
            puis_nxt = cmd.puis_val;
          end
          spin_nxt = cmd.spinup;
          if (cmd.link_set) begin
            link_nxt = cmd.link_val ? (link_r | cmd.link_mask) : (link_r & ~cmd.link_mask);
          end
          if (cmd.xfer_set) begin
            xfer_nxt = count_r;
          end
          stime_nxt = cmd.sector_time;
          epc_nxt = cmd.extended_power_condition_group;
        end
        err_nxt = '0;
        err_nxt[TSFS_ERR_ABT] = abort_now;
        state_nxt = TSFS_ST_DONE;
      end
      TSFS_ST_DONE: begin
        stat_nxt = '0;
        stat_nxt[TSFS_ST_RDY] = 1'b1;
        stat_nxt[TSFS_ST_ERR] = err_r[TSFS_ERR_ABT];
        done_nxt = 1'b1;
        state_nxt = TSFS_ST_IDLE;
      end
      default: state_nxt = TSFS_ST_IDLE;
    endcase
    if (spare_nxt) begin
      wc_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers; reset gives power-on feature defaults
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_r <= TSFS_ST_IDLE;
      opcode_r <= '0;
      feature_r <= '0;
      count_r <= '0;
      err_r <= '0;
      stat_r <= 8'h40;
      scnt_r <= '0;
      done_r <= 1'b0;
      wc_r <= 1'b1;
      rla_r <= 1'b1;
      revert_r <= 1'b0;
      apm_r <= 1'b0;
      deep_r <= TSFS_DEEP_IDLE;
      level_r <= '0;
      puis_r <= 1'b0;
      spin_r <= 1'b0;
      link_r <= '0;
      xfer_r <= TSFS_XFER_RESET;
      stime_r <= 1'b0;
      epc_r <= 1'b0;
      spare_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      opcode_r <= opcode_nxt;
      feature_r <= feature_nxt;
      count_r <= count_nxt;
      err_r <= err_nxt;
      stat_r <= stat_nxt;
      scnt_r <= scnt_nxt;
      done_r <= done_nxt;
      wc_r <= wc_nxt;
      rla_r <= rla_nxt;
      revert_r <= revert_nxt;
      apm_r <= apm_nxt;
      deep_r <= deep_nxt;
      level_r <= level_nxt;
      puis_r <= puis_nxt;
      spin_r <= spin_nxt;
      link_r <= link_nxt;
      xfer_r <= xfer_nxt;
      stime_r <= stime_nxt;
      epc_r <= epc_nxt;
      spare_r <= spare_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from flops, release interrupt tied low
  // ----------------------------------------------------------------
  assign command_error_flags_out = err_r;
  assign device_status_flags_out = stat_r;
  assign sector_count_out = scnt_r;
  assign done_out = done_r;
  assign write_cache_out = wc_r;
  assign read_ahead_out = rla_r;
  assign revert_defaults_out = revert_r;
  assign release_irq_out = 1'b0; // no release interrupt support, stays disabled
  assign apm_enable_out = apm_r;
  assign apm_deep_out = deep_r;
  assign apm_level_out = level_r;
  assign puis_enable_out = puis_r;
  assign spinup_req_out = spin_r;
  assign link_features_out = link_r;
  assign xfer_mode_out = xfer_r;
  assign sector_time_req_out = stime_r;
  assign extended_power_condition_group_out = epc_r;
  // identify words mirror the live cache flop
  always_comb begin
    identify_word85_out = '0;
    identify_word85_out[TSFS_ID85_WC_BIT] = wc_r;
    identify_word129_out = '0;
    identify_word129_out[TSFS_ID129_WC_BIT] = wc_r;
  end
endmodule // tsfs_cmd_engine

// *** tb/tsfs_props.sv ***
// Purpose: port checks on the command engine
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every engine instance
`timescale 1ns/1ps
module tsfs_props (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_strobe_in,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic [7:0] feature_in,
  input wire logic [9:0] temp_half_deg_in,
  input wire logic spares_exhausted_in,
  input wire logic [7:0] command_error_flags_out,
  input wire logic [7:0] device_status_flags_out,
  input wire logic [7:0] sector_count_out,
  input wire logic done_out,
  input wire logic write_cache_out,
  input wire logic read_ahead_out,
  input wire logic release_irq_out,
  input wire logic spinup_req_out,
  input wire logic sector_time_req_out,
  input wire logic extended_power_condition_group_out,
  input wire logic [15:0] identify_word85_out,
  input wire logic [15:0] identify_word129_out
);
  import tsfs_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic spent_r, spent_nxt;
  // ----------------------------------------------------------------
  // spare exhaustion memory, sticky until reset
  // ----------------------------------------------------------------
  always_comb spent_nxt = rst_n_in & (spent_r | spares_exhausted_in);
  always_ff @(posedge sys_clk_in) spent_r <= spent_nxt;
  // expected temperature code
  function automatic logic [7:0] tcode(input logic [9:0] t);
    return (t == 10'h000) ? 8'h00 : (t > 10'h0FE) ? 8'hFF : t[7:0];
  endfunction
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  sequence s_take;
    cmd_strobe_in && !device_status_flags_out[TSFS_ST_BSY] && cmd_opcode_in inside {8'hF0, 8'hEF};
  endsequence
  sequence s_take_fc(logic [7:0] fc);
    s_take ##0 (cmd_opcode_in == 8'hEF && feature_in == fc);
  endsequence
  sequence s_finish;
    device_status_flags_out == 8'h80 ##1 device_status_flags_out[TSFS_ST_BSY] ##1
      (done_out && device_status_flags_out[TSFS_ST_RDY] && !device_status_flags_out[TSFS_ST_BSY]);
  endsequence
  property p_walk; s_take |=> s_finish; endproperty
  property p_err; done_out |-> device_status_flags_out[0] == command_error_flags_out[2] &&
    (command_error_flags_out & 8'hFB) == 8'h00; endproperty
  property p_temp_bad; s_take ##0 (cmd_opcode_in == 8'hF0 && feature_in != 8'h01) |->
    ##3 command_error_flags_out[2] && sector_count_out == $past(sector_count_out, 3); endproperty
  property p_temp_res; s_take ##0 (cmd_opcode_in == 8'hF0 && feature_in == 8'h01) |->
    ##3 (sector_count_out == tcode($past(temp_half_deg_in, 2)) && !command_error_flags_out[2]); endproperty
  property p_undef; s_take ##0 (cmd_opcode_in == 8'hEF && !(feature_in inside {8'h02, 8'h03, 8'h05,
    8'h06, 8'h07, 8'h10, 8'h43, 8'h4A, 8'h55, 8'h66, 8'h82, 8'h85, 8'h86, 8'h90, 8'hAA, 8'hCC}))
    |-> ##3 command_error_flags_out[2]; endproperty
  property p_wc; s_take_fc(8'h02) |-> ##3 (write_cache_out || spent_r); endproperty
  property p_rla; s_take_fc(8'h55) |-> ##3 !read_ahead_out; endproperty
  property p_spent; $past(spent_r) |-> !write_cache_out; endproperty
  property p_ident; identify_word85_out[5] == write_cache_out &&
    identify_word129_out[0] == write_cache_out; endproperty
  property p_reset; $rose(rst_n_in) |-> device_status_flags_out == 8'h40 && write_cache_out &&
    read_ahead_out && !release_irq_out; endproperty
  property p_spin; s_take_fc(8'h07) |-> ##2 spinup_req_out ##1 !spinup_req_out; endproperty
  property p_sect; s_take_fc(8'h43) |-> ##2 sector_time_req_out; endproperty
  property p_epc; s_take_fc(8'h4A) |-> ##2 extended_power_condition_group_out; endproperty
  a_walk: assert property (p_walk) else $error("bad walk");
  a_err: assert property (p_err) else $error("error bit");
  a_temp_bad: assert property (p_temp_bad) else $error("no temp abort");
  a_temp_res: assert property (p_temp_res) else $error("bad temp code");
  a_undef: assert property (p_undef) else $error("no abort");
  a_wc: assert property (p_wc) else $error("cache off");
  a_rla: assert property (p_rla) else $error("look-ahead on");
  a_spent: assert property (p_spent) else $error("cache on");
  a_ident: assert property (p_ident) else $error("identify bits");
  a_reset: assert property (p_reset) else $error("bad defaults");
  a_spin: assert property (p_spin) else $error("bad spin-up");
  a_sect: assert property (p_sect) else $error("no sector time");
  a_epc: assert property (p_epc) else $error("no power group");
endmodule // tsfs_props
bind tsfs_cmd_engine tsfs_props tsfs_props_inst (.*);

// *** tb/tsfs_host_model.sv ***
// Purpose: host side writing the command block registers
// Assumes: drives on falling edges
// Notes: released lines show the inverse of the last value
`timescale 1ns/1ps
module tsfs_host_model (
  input wire logic sys_clk_in,
  input wire logic done_in,
  output logic cmd_strobe_out,
  output logic [7:0] cmd_opcode_out,
  output logic [7:0] feature_out,
  output logic [7:0] sector_count_out
);
  int late = 0;
  // ----------------------------------------------------------------
  // idle lines, then one command per call
  // ----------------------------------------------------------------
  initial begin
    cmd_strobe_out = 1'b0;
    cmd_opcode_out = 8'h00;
    feature_out = 8'h00;
    sector_count_out = 8'h00;
  end
  task automatic issue(input logic [7:0] op, input logic [7:0] fc, input logic [7:0] cnt);
    int n = 0;
    @(negedge sys_clk_in);
    cmd_strobe_out = 1'b1;
    cmd_opcode_out = op;
    feature_out = fc;
    sector_count_out = cnt;
    @(negedge sys_clk_in);
    // inverted so a late sample of stale values shows up
    cmd_strobe_out = 1'b0;
    cmd_opcode_out = ~op;
    feature_out = ~fc;
    sector_count_out = ~cnt;
    while (done_in !== 1'b1 && n < 6) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n == 6) late++;
  endtask
endmodule // tsfs_host_model

// *** tb/tb.sv ***
// Purpose: self-checking bench for the command engine
// Assumes: host model issues commands
// Notes: fixed seed, corner values mixed with random ones
`timescale 1ns/1ps
module tb;
  import tsfs_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic spares = 1'b0;
  logic [9:0] temp = 10'h000;
  logic strobe, done, wc, ra, rev, irq, apm_en, puis;
  logic [7:0] op, fc, cnt, err, stat, cnt_o, lvl, xfer, prev, tv, rnd;
  logic [1:0] deep;
  logic [4:0] link;
  logic [15:0] id85, id129;
  int mismatches = 0;
  int n_tests = 0;
  logic [7:0] fcs [11] = '{8'h82, 8'h02, 8'h55, 8'hAA, 8'h66, 8'hCC, 8'h86, 8'h06, 8'h07, 8'h43, 8'h4A};
  logic [3:0] st [11] = '{4'h4, 4'hC, 4'h8, 4'hC, 4'hC, 4'hE, 4'hE, 4'hF, 4'hF, 4'hF, 4'hF};
  logic [9:0] tt [6] = '{10'h000, 10'h001, 10'h002, 10'h0FE, 10'h0FF, 10'h3FF};
  logic [7:0] lv [8] = '{8'hC0, 8'hFE, 8'h80, 8'hBF, 8'h01, 8'h7F, 8'h00, 8'hFF};
  logic [7:0] ls [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06};
  always #4 sys_clk_in = ~sys_clk_in;
  tsfs_host_model tsfs_host_model_inst (.sys_clk_in, .done_in(done), .cmd_strobe_out(strobe),
    .cmd_opcode_out(op), .feature_out(fc), .sector_count_out(cnt));
  tsfs_cmd_engine tsfs_cmd_engine_inst (.sys_clk_in, .rst_n_in, .cmd_strobe_in(strobe),
    .cmd_opcode_in(op), .feature_in(fc), .sector_count_in(cnt), .temp_half_deg_in(temp),
    .spares_exhausted_in(spares), .command_error_flags_out(err), .device_status_flags_out(stat),
    .sector_count_out(cnt_o), .done_out(done), .write_cache_out(wc), .read_ahead_out(ra),
    .revert_defaults_out(rev), .release_irq_out(irq), .apm_enable_out(apm_en), .apm_deep_out(deep),
    .apm_level_out(lvl), .puis_enable_out(puis), .spinup_req_out(), .link_features_out(link),
    .xfer_mode_out(xfer), .sector_time_req_out(), .extended_power_condition_group_out(),
    .identify_word85_out(id85), .identify_word129_out(id129));
  // ----------------------------------------------------------------
  // expectation helpers and checking tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] tcode(input logic [9:0] t);
    return (t == 10'h000) ? 8'h00 : (t > 10'h0FE) ? 8'hFF : t[7:0];
  endfunction
  function automatic logic xok(input logic [7:0] s);
    case (s[7:3])
      5'h00: return s[2:0] <= 3'h1;
      5'h01: return s[2:0] <= 3'h4;
      5'h04: return s[2:0] <= 3'h2;
      5'h08: return s[2:0] <= 3'h6;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic fdef(input logic [7:0] f);
    return f inside {8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h10, 8'h43, 8'h4A, 8'h55, 8'h66, 8'h82, 8'h85,
      8'h86, 8'h90, 8'hAA, 8'hCC};
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // feature command, then error and status
  task automatic feat(input logic [7:0] f, input logic [7:0] c, input logic ab);
    tsfs_host_model_inst.issue(8'hEF, f, c);
    chk("error", {8'h00, err}, ab ? 16'h0004 : 16'h0000);
    chk("status", {8'h00, stat}, ab ? 16'h0041 : 16'h0040);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rnd = 8'($urandom(32'h018C));
    repeat (2) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    chk("reset", {8'h00, stat}, 16'h0040);
    chk("defaults", {12'h000, wc, ra, irq, rev}, 16'h000C);
    foreach (fcs[i]) begin
      feat(fcs[i], 8'($urandom), 1'b0);
      chk("levels", {12'h000, wc, ra, rev, puis}, {12'h000, st[i]});
    end
    // standby still enabled: temperature must run from it
    for (int i = 0; i < 12; i++) begin
      temp = (i < 6) ? tt[i] : 10'($urandom);
      tsfs_host_model_inst.issue(8'hF0, 8'h01, 8'($urandom));
      chk("temp", {8'h00, cnt_o}, {8'h00, tcode(temp)});
      chk("temp_err", {err, stat}, 16'h0040);
    end
    for (int j = 0; j < 2; j++) begin
      tv = j ? 8'($urandom_range(2, 255)) : 8'h00;
      tsfs_host_model_inst.issue(8'hF0, tv, 8'h00);
      chk("temp_abort", {err, stat}, 16'h0441);
      chk("temp_kept", {8'h00, cnt_o}, {8'h00, tcode(temp)});
    end
    for (int i = 0; i < 6; i++) begin
      do tv = 8'($urandom); while (fdef(tv));
      feat(tv, 8'($urandom), 1'b1);
    end
    foreach (lv[i]) begin
      feat(8'h05, lv[i], lv[i] == 8'h00 || lv[i] == 8'hFF);
      if (lv[i] != 8'h00 && lv[i] != 8'hFF) prev = lv[i];
      chk("apm", {5'h00, apm_en, deep, lvl}, {5'h01, (prev >= 8'hC0) ? 2'h0 : (prev >= 8'h80) ? 2'h1 : 2'h2,
        prev});
    end
    feat(8'h85, 8'($urandom), 1'b0);
    chk("apm_off", {7'h00, apm_en, lvl}, 16'h0000);
    foreach (ls[i]) begin
      feat(8'h10, ls[i], 1'b0);
      chk("link", {11'h000, link}, 16'((2 << i) - 1));
    end
    feat(8'h10, 8'h05, 1'b1);
    feat(8'h90, 8'h03, 1'b0);
    chk("link_off", {11'h000, link}, 16'h001B);
    prev = 8'h00;
    for (int i = 0; i < 256; i++) begin
      tv = 8'(i * 37) + rnd;
      feat(8'h03, tv, !xok(tv));
      if (xok(tv)) prev = tv;
      chk("xfer", {8'h00, xfer}, {8'h00, prev});
    end
    chk("ident", {14'h0000, id85[5], id129[0]}, 16'h0003);
    spares = 1'b1;
    @(negedge sys_clk_in);
    spares = 1'b0;
    @(negedge sys_clk_in);
    chk("wc_spent", {14'h0000, wc, id85[5]}, 16'h0000);
    feat(8'h02, 8'h00, 1'b0);
    chk("wc_kept", {14'h0000, wc, id129[0]}, 16'h0000);
    rst_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    chk("reset2", {5'h00, wc, ra, irq, stat}, 16'h0640);
    chk("late", 16'(tsfs_host_model_inst.late), 16'h0000);
    results();
  end
  // hang guard, far beyond the run's length
  initial begin
    #160000;
    mismatches++;
    results();
  end
endmodule // tb
